// [design/rcfr_pkg.sv]
package rcfr_pkg;
  localparam logic [11:0] RCFR_ADDR_SECONDARY = 12'hfd6;
  localparam logic [11:0] RCFR_ADDR_FLAGS     = 12'hfd7;
  localparam logic [11:0] RCFR_ADDR_BROWNOUT  = 12'hedb;
  localparam logic [11:0] RCFR_ADDR_IRQ_STAT  = 12'hfd0;
  localparam logic [11:0] RCFR_ADDR_IRQ_MASK  = 12'hfd1;
  localparam int RCFR_BIT_OVERFLOW  = 7;
  localparam int RCFR_BIT_UNDERFLOW = 6;
  localparam int RCFR_BIT_WINVIO  = 5;
  localparam int RCFR_BIT_WDTO    = 4;
  localparam int RCFR_BIT_PIN     = 3;
  localparam int RCFR_BIT_RSTINS  = 2;
  localparam int RCFR_BIT_POWERON = 1;
  localparam int RCFR_BIT_BROWN   = 0;
  localparam int RCFR_BIT_VREG    = 2;
  localparam int RCFR_BIT_CFGMEM  = 0;
  localparam int RCFR_BIT_ARMED   = 0;
  localparam int RCFR_BIT_SWBOREN = 7;
  localparam logic [7:0] RCFR_FLAGS_WMASK     = 8'hff;
  localparam logic [7:0] RCFR_SECONDARY_WMASK = 8'h05;
  localparam logic [7:0] RCFR_FLAGS_POR_RST   = 8'h3c;
  localparam logic [7:0] RCFR_SECONDARY_RST   = 8'h05;
  localparam logic       RCFR_SWBOREN_RST     = 1'b1;
  localparam logic [9:0] RCFR_IRQ_MASK_RST    = 10'h000;
endpackage

// [design/rcfr_reset_cause.sv]
// Behaviour
// RQ1: Stack overflow sets bit 7, cleared by power-on/brown-out reset, firmware writable.
// RQ2: Stack underflow sets bit 6, cleared by power-on/brown-out reset, firmware writable.
// RQ3: A watchdog clear in a closed window clears bit 5; power-on/brown-out reset sets it.
// RQ4: A watchdog time-out clears bit 4; power-on/brown-out reset sets it; firmware writable.
// RQ5: A clear-pin reset clears bit 3; power-on/brown-out reset sets it.
// RQ6: A reset instruction clears bit 2; power-on/brown-out reset sets it; firmware writable.
// RQ7: Power-on reset clears bit 1, other resets leave it; firmware may set it.
// RQ8: Brown-out reset clears bit 0, other non-power-on resets leave it; firmware may set it.
// RQ9: A regulator ready fault clears the regulator flag in the secondary register.
// RQ10: The secondary register keeps a configuration-memory corruption flag, set by power-on.
// RQ11: The brown-out armed status reads 1 when armed and 0 when off or warming up.
// RQ12: The flag registers sit at 0xfd7 and 0xfd6, each 8 bits wide.
// RQ13: A reset event other than power-on or brown-out changes only the flag of its own cause.
// RQ14: Firmware returns each flag to inactive after restart; hardware does so only for bits 7..2, on power-on/brown-out reset.
// RQ15: A firmware write of an active value is stored and causes no reset.
// RQ16: Events are clock-synchronous pulses; an event beats a write to the same flag.
module rcfr_reset_cause
  import rcfr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        power_on_event,
  input  wire logic        brownout_event,
  input  wire logic        stack_overflow_event,
  input  wire logic        stack_underflow_event,
  input  wire logic        window_violation_event,
  input  wire logic        watchdog_timeout_event,
  input  wire logic        clear_pin_event,
  input  wire logic        reset_instruction_event,
  input  wire logic        regulator_fault_event,
  input  wire logic        config_memory_event,
  input  wire logic        brownout_armed,
  input  wire logic [11:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  output logic             sw_brownout_enable,
  output logic             irq
);

  logic [7:0] power_control_reset_flags;
  logic [7:0] power_control_secondary_flags;
  logic       swboren;
  logic [9:0] irq_status;
  logic [9:0] irq_mask;

  // Power-on and brown-out both restore the documented reset pattern in flag bits 7..2
  wire logic supply_reset = power_on_event | brownout_event;

  wire logic sel_flags     = addr == RCFR_ADDR_FLAGS;
  wire logic sel_secondary = addr == RCFR_ADDR_SECONDARY;
  wire logic sel_brownout  = addr == RCFR_ADDR_BROWNOUT;
  wire logic sel_istat     = addr == RCFR_ADDR_IRQ_STAT;
  wire logic sel_imask     = addr == RCFR_ADDR_IRQ_MASK;

  wire logic wr_flags     = wr & sel_flags;
  wire logic wr_secondary = wr & sel_secondary;

  // Events that force a bit high (set) and low (clear)
  wire logic [7:0] hw_set_flags = {stack_overflow_event, stack_underflow_event, 6'h00}; // RQ1 RQ2
  wire logic [7:0] hw_clr_flags = {2'h0,
                                   window_violation_event,  // RQ3
                                   watchdog_timeout_event,  // RQ4
                                   clear_pin_event,         // RQ5
                                   reset_instruction_event, // RQ6
                                   power_on_event,          // RQ7
                                   brownout_event};         // RQ8
  wire logic [7:0] hw_clr_sec   = {5'h00, regulator_fault_event, 2'h0}; // RQ9
  wire logic [7:0] hw_set_sec   = {7'h00, config_memory_event};          // RQ10

  // Firmware write merged first so that hardware events override it
  wire logic [7:0] fw_flags = wr_flags ? (wdata & RCFR_FLAGS_WMASK)
                                       : power_control_reset_flags; // RQ15
  wire logic [7:0] fw_sec   = wr_secondary ? (wdata & RCFR_SECONDARY_WMASK)
                                           : power_control_secondary_flags;

  // Supply reset: bits 7..2 to pattern, bit 1 per cause, bit 0 cleared on brown-out
  wire logic [7:0] sup_flags = {RCFR_FLAGS_POR_RST[7:2],
                                power_on_event ? 1'b0 : fw_flags[RCFR_BIT_POWERON], // RQ7
                                brownout_event ? 1'b0 :
                                  (power_on_event ? fw_flags[RCFR_BIT_BROWN] : 1'b0)}; // RQ8

  wire logic [7:0] next_power_control_reset_flags =
    supply_reset ? sup_flags
                 : ((fw_flags & ~hw_clr_flags) | hw_set_flags); // RQ13 RQ16
  wire logic [7:0] next_power_control_secondary_flags =
    supply_reset ? (RCFR_SECONDARY_RST & ~hw_clr_sec)              // RQ9 RQ10
                 : ((fw_sec & ~hw_clr_sec) | hw_set_sec);           // RQ13 RQ16

  wire logic [9:0] events = {stack_overflow_event, stack_underflow_event,
                             window_violation_event, watchdog_timeout_event,
                             clear_pin_event, reset_instruction_event,
                             power_on_event, brownout_event,
                             regulator_fault_event, config_memory_event};
  wire logic [9:0] istat_clr = (wr & sel_istat) ? {wdata, 2'b00} : 10'h000;
  wire logic [9:0] next_irq_status = (irq_status & ~istat_clr) | events;

  wire logic [7:0] brownout_read = {swboren, 6'h00, brownout_armed}; // RQ11

  wire logic [7:0] read_mux =
    sel_flags     ? power_control_reset_flags :
    sel_secondary ? power_control_secondary_flags :
    sel_brownout  ? brownout_read :
    sel_istat     ? irq_status[9:2] :
    sel_imask     ? irq_mask[9:2] : 8'h00;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      power_control_reset_flags     <= RCFR_FLAGS_POR_RST;
      power_control_secondary_flags <= RCFR_SECONDARY_RST;
      swboren                       <= RCFR_SWBOREN_RST;
      irq_status                    <= 10'h000;
      irq_mask                      <= RCFR_IRQ_MASK_RST;
      rdata                         <= 8'h00;
    end else begin
      power_control_reset_flags     <= next_power_control_reset_flags; // RQ12
      power_control_secondary_flags <= next_power_control_secondary_flags; // RQ12
      irq_status                    <= next_irq_status;
      rdata                         <= rd ? read_mux : 8'h00;
      if (supply_reset) begin
        swboren <= RCFR_SWBOREN_RST;
      end else if (wr & sel_brownout) begin
        swboren <= wdata[RCFR_BIT_SWBOREN];
      end
      if (wr & sel_imask) begin
        irq_mask <= {wdata, 2'b00};
      end
    end
  end

  assign sw_brownout_enable = swboren;
  assign irq                = |(irq_status & irq_mask);

endmodule // rcfr_reset_cause

// [tb/rcfr_reset_cause_monitor.sv]
module rcfr_reset_cause_monitor
  import rcfr_pkg::*;
(
  input wire logic        clk, nrst, power_on_event, brownout_event, stack_overflow_event,
  input wire logic        watchdog_timeout_event, clear_pin_event, brownout_armed, rd,
  input wire logic [11:0] addr,
  input wire logic [7:0]  rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic rf = rd && addr == RCFR_ADDR_FLAGS;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_rdata_idle: assert property (!rd |=> rdata == 8'h00) else $error("rdata not idle");
  a_ovf_sets: assert property (stack_overflow_event ##1 rf |=> rdata[7])
    else $error("overflow flag not set");
  a_wdto_clears: assert property (watchdog_timeout_event ##1 rf |=> !rdata[4])
    else $error("time-out flag not cleared");
  a_pin_clears: assert property (clear_pin_event ##1 rf |=> !rdata[3])
    else $error("pin flag not cleared");
  a_por_pattern: assert property (power_on_event ##1 rf |=> rdata[7:1] == 7'h1e)
    else $error("power-on pattern wrong");
  a_bor_clears: assert property (brownout_event ##1 rf |=> !rdata[0])
    else $error("brown-out flag not cleared");
  a_armed_read: assert property (rd && addr == RCFR_ADDR_BROWNOUT |=>
    rdata[0] == $past(brownout_armed)) else $error("armed status wrong");
  a_sec_unused: assert property (rd && addr == RCFR_ADDR_SECONDARY |=>
    (rdata & 8'hfa) == 8'h00) else $error("secondary unused bits set");
  c_wdto: cover property (watchdog_timeout_event ##1 rf);
  c_por: cover property (power_on_event ##1 rf);
  c_armed: cover property (rd && addr == RCFR_ADDR_BROWNOUT);
endmodule // rcfr_reset_cause_monitor
bind rcfr_reset_cause rcfr_reset_cause_monitor u_mon (.clk, .nrst, .power_on_event, .brownout_event,
  .stack_overflow_event, .watchdog_timeout_event, .clear_pin_event, .brownout_armed, .rd, .addr,
  .rdata);

// [tb/rcfr_event_src.sv]
module rcfr_event_src (
  input  wire logic       clk,
  input  wire logic [9:0] fire,
  output logic      [9:0] ev
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk) ev <= fire;
endmodule // rcfr_event_src

// [tb/rcfr_reset_cause_tb.sv]
module rcfr_reset_cause_tb
  import rcfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, nrst = 0, wr = 0, rd = 0, armed = 1, sw_en, irq;
  logic [11:0] addr = 12'h000;
  logic [7:0]  wdata = 8'h00, rdata;
  logic [9:0]  fire = 10'h000, ev;
  int fails = 0, comparisons = 0;
  always #10 clk = ~clk;
  rcfr_event_src src (.clk, .fire, .ev);
  rcfr_reset_cause dut (.clk, .nrst, .power_on_event(ev[0]), .brownout_event(ev[1]),
    .stack_overflow_event(ev[2]), .stack_underflow_event(ev[3]), .window_violation_event(ev[4]),
    .watchdog_timeout_event(ev[5]), .clear_pin_event(ev[6]), .reset_instruction_event(ev[7]),
    .regulator_fault_event(ev[8]), .config_memory_event(ev[9]), .brownout_armed(armed),
    .addr, .wdata, .wr, .rd, .rdata, .sw_brownout_enable(sw_en), .irq);
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wreg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk); wr <= 1; addr <= a; wdata <= d;
    @(posedge clk); wr <= 0;
  endtask
  task rreg(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk); rd <= 1; addr <= a;
    @(posedge clk); rd <= 0;
    #1 chk(rdata, e);
  endtask
  task pulse(input int i);
    @(posedge clk); fire <= 10'h001 << i;
    @(posedge clk); fire <= 10'h000;
  endtask
  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    report_and_stop;
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1;
    rreg(RCFR_ADDR_FLAGS, 8'h3c);
    rreg(RCFR_ADDR_SECONDARY, 8'h05);
    rreg(RCFR_ADDR_BROWNOUT, 8'h81);
    rreg(12'hfd5, 8'h00);
    wreg(RCFR_ADDR_FLAGS, 8'hc3);
    rreg(RCFR_ADDR_FLAGS, 8'hc3);
    pulse(0);
    rreg(RCFR_ADDR_FLAGS, 8'h3d);
    wreg(RCFR_ADDR_FLAGS, 8'hff);
    pulse(1);
    rreg(RCFR_ADDR_FLAGS, 8'h3e);
    for (int i = 2; i < 8; i++) begin
      wreg(RCFR_ADDR_FLAGS, i < 4 ? 8'h00 : 8'hff);
      pulse(i);
      rreg(RCFR_ADDR_FLAGS, i < 4 ? 8'h01 << (9 - i) : 8'hff ^ (8'h01 << (9 - i)));
    end
    pulse(8);
    rreg(RCFR_ADDR_SECONDARY, 8'h01);
    wreg(RCFR_ADDR_SECONDARY, 8'h00);
    pulse(9);
    rreg(RCFR_ADDR_SECONDARY, 8'h01);
    rreg(RCFR_ADDR_IRQ_STAT, 8'hff);
    chk({7'h00, irq}, 8'h00);
    wreg(RCFR_ADDR_IRQ_MASK, 8'h10);
    #1 chk({7'h00, irq}, 8'h01);
    wreg(RCFR_ADDR_IRQ_STAT, 8'hff);
    #1 chk({7'h00, irq}, 8'h00);
    rreg(RCFR_ADDR_IRQ_STAT, 8'h00);
    wreg(RCFR_ADDR_BROWNOUT, 8'h00);
    armed <= 0;
    rreg(RCFR_ADDR_BROWNOUT, 8'h00);
    chk({7'h00, sw_en}, 8'h00);
    report_and_stop;
  end
endmodule // rcfr_reset_cause_tb
